// [rtl/urs_ctrl.sv]
// Operation
// - both resets act identically
// - ident reads no-interrupt code after reset
// - line control 0x1d, status bits 5,6
// - modem deltas clear, upper bits follow pins
// - tx space 0x40, rx level zero
// - reset clears control registers except line control, and pointers
// - divisor, scratch, flow chars survive reset
// - modem outputs high, gpio inputs, irq released
// - codes for none, line, timeout, data
// - codes for tx, modem, gpio, flow, handshake
// - each source gated, irq only when enabled
// - error summary while any fifo error remains
// - head error bits, zero when empty
// - flow stop clears on resume, special on read
// - any set enable bit other than the sleep bit selects interrupt mode
// - sleep allowed only with both enables
// - sleep only when fully idle
// - wake on rx, modem change, tx write
// - timeout four characters after last activity
// - break after low beyond one frame
// - break bit holds tx low
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
module urs_ctrl
    import urs_pkg::*;
(
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        rst_in,
    // register port
    input  wire logic [4:0]  addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [7:0]  rdata_out,
    // serial line
    input  wire logic        rx_in,
    input  wire logic        tx_ser_in,
    input  wire logic        bit_tick_in,
    output logic             tx_out,
    // receiver events
    input  wire logic        rx_push_in,
    input  wire logic [7:0]  rx_data_in,
    input  wire logic [2:0]  rx_err_in,
    input  wire logic        stop_mid_in,
    // transmitter
    input  wire logic        tx_pop_in,
    input  wire logic        tx_shift_empty_in,
    output logic             tx_load_out,
    output logic      [7:0]  tx_data_out,
    // flow character detection
    input  wire logic        resume_det_in,
    input  wire logic        stop_det_in,
    input  wire logic        special_det_in,
    // modem pins
    input  wire logic [3:0]  modem_in,
    output logic             dtr_n_out,
    output logic             rts_n_out,
    // gpio pins
    input  wire logic [7:0]  gpio_in,
    output logic      [7:0]  gpio_out,
    output logic      [7:0]  gpio_oe_n_out,
    // interrupt, open drain
    output logic             irq_out,
    output logic             irq_oe_n_out,
    // clocking
    output logic             sleep_out,
    output logic      [15:0] divisor_out
);
    logic        rst_int, swrst_reg, init_reg;
    logic [7:0]  ier_reg, fcr_reg, lcr_reg, mcr_reg, efr_reg, tcr_reg, tlr_reg;
    logic [7:0]  iodir_reg, iostate_reg, ioien_reg, ioctl_reg, efcr_reg;
    logic [7:0]  dll_reg, dlh_reg, spr_reg, res1_reg, res2_reg, stp1_reg, stp2_reg;
    logic [10:0] mem [0:63];
    logic [5:0]  wptr_reg, rptr_reg;
    logic [6:0]  rx_cnt_reg, err_cnt_reg, tx_space_reg, trig;
    logic [10:0] head, push_d;
    logic        wr_data, rd_data, pop, push_v, brk_push, brk_hit, brk_done_reg;
    logic        ovr_reg, thr_reg, stop_src_reg, spec_src_reg, rts_chg_reg, cts_chg_reg;
    logic [3:0]  msr_delta_reg, modem_d_reg;
    logic [7:0]  gpio_chg_reg, gpio_d_reg, line_status_reg, rd_mux, char_bits;
    logic        rx_d_reg, rts_d_reg, tmo_hit, tmo_p, rls_p, rxd_p, txe_p;
    logic        msr_p, gpio_p, flow_p, hs_p, sleep_ok, idle, wake;
    logic [5:0]  ident;
    urs_sleep_e  slp_reg;

    // software reset is a registered pulse so the derived reset is glitch free
    assign rst_int = rst_in | swrst_reg;
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            swrst_reg <= 1'b0;
        end else begin
            swrst_reg <= wr_in && addr_in == ADR_IO_CTL && wdata_in[IOCTL_SWR];
        end
    end

    // pin history is only trusted one cycle after reset
    always_ff @(posedge clock_in or posedge rst_int) begin
        if (rst_int) begin
            init_reg <= 1'b0;
        end else begin
            init_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        rx_d_reg    <= rx_in;
        modem_d_reg <= modem_in;
        gpio_d_reg  <= gpio_in;
        rts_d_reg   <= rts_n_out;
    end

    assign wr_data = wr_in && addr_in == ADR_DATA;
    assign rd_data = rd_in && addr_in == ADR_DATA;

    // control registers, cleared by any reset except line control, which loads 0x1d
    always_ff @(posedge clock_in or posedge rst_int) begin
        if (rst_int) begin
            ier_reg   <= 8'h00;
            fcr_reg   <= 8'h00;
            lcr_reg   <= LINE_CTL_RST;
            mcr_reg   <= 8'h00;
            efr_reg   <= 8'h00;
            tcr_reg   <= 8'h00;
            tlr_reg   <= 8'h00;
            iodir_reg <= 8'h00;
            ioien_reg <= 8'h00;
            ioctl_reg <= 8'h00;
            efcr_reg  <= 8'h00;
            iostate_reg <= 8'h00;
        end else if (wr_in) begin
            case (addr_in)
                ADR_IEN:       ier_reg   <= wdata_in;
                ADR_IDENT:     fcr_reg   <= wdata_in;
                ADR_LINE_CTL:  lcr_reg   <= wdata_in;
                ADR_MODEM_CTL: mcr_reg   <= wdata_in;
                ADR_FEAT:      efr_reg   <= wdata_in;
                ADR_FLOW_THR:  tcr_reg   <= wdata_in;
                ADR_TRIG_THR:  tlr_reg   <= wdata_in;
                ADR_IO_DIR:    iodir_reg <= wdata_in;
                ADR_IO_IEN:    ioien_reg <= wdata_in;
                ADR_IO_CTL:    ioctl_reg <= wdata_in & 8'hf7;
                ADR_XFEAT:     efcr_reg  <= wdata_in;
                ADR_IO_STATE:  iostate_reg <= wdata_in;
                default:       ;
            endcase
        end
    end

    // retained registers carry no reset at all
    always_ff @(posedge clock_in) begin
        if (wr_in) begin
            case (addr_in)
                ADR_DIV_LO:  dll_reg  <= wdata_in;
                ADR_DIV_HI:  dlh_reg  <= wdata_in;
                ADR_SCRATCH: spr_reg  <= wdata_in;
                ADR_RESUME1: res1_reg <= wdata_in;
                ADR_RESUME2: res2_reg <= wdata_in;
                ADR_STOP1:   stp1_reg <= wdata_in;
                ADR_STOP2:   stp2_reg <= wdata_in;
                default:     ;
            endcase
        end
    end

    // pins; mcr bits are active high so reset leaves both pins high
    assign dtr_n_out     = ~mcr_reg[0];
    assign rts_n_out     = ~mcr_reg[1];
    assign gpio_oe_n_out = ~iodir_reg;
    assign gpio_out      = iostate_reg;
    assign divisor_out   = {dlh_reg, dll_reg};
    assign tx_out        = lcr_reg[LCTL_BRK] ? 1'b0 : tx_ser_in;

    // receive fifo; a detected break enters as a zero character
    assign pop      = rd_data && rx_cnt_reg != 7'h00;
    assign push_v   = rx_push_in | brk_push;
    assign push_d   = rx_push_in ? {rx_err_in, rx_data_in} : 11'h400;
    assign head     = mem[rptr_reg];
    always_ff @(posedge clock_in) begin
        if (push_v && rx_cnt_reg != FIFO_DEPTH) begin
            mem[wptr_reg] <= push_d;
        end
    end

    always_ff @(posedge clock_in or posedge rst_int) begin
        if (rst_int) begin
            wptr_reg    <= 6'h00;
            rptr_reg    <= 6'h00;
            rx_cnt_reg  <= 7'h00;
            err_cnt_reg <= 7'h00;
        end else begin
            if (push_v && rx_cnt_reg != FIFO_DEPTH) begin
                wptr_reg <= wptr_reg + 6'h01;
            end
            if (pop) begin
                rptr_reg <= rptr_reg + 6'h01;
            end
            rx_cnt_reg  <= rx_cnt_reg + {6'h00, push_v && rx_cnt_reg != FIFO_DEPTH}
                           - {6'h00, pop};
            err_cnt_reg <= err_cnt_reg
                           + {6'h00, push_v && rx_cnt_reg != FIFO_DEPTH && |push_d[10:8]}
                           - {6'h00, pop && |head[10:8]};
        end
    end

    // transmit space, a write into a full fifo is dropped
    always_ff @(posedge clock_in or posedge rst_int) begin
        if (rst_int) begin
            tx_space_reg <= TX_SPACE_RST;
            tx_load_out  <= 1'b0;
            tx_data_out  <= 8'h00;
        end else begin
            tx_load_out  <= wr_data && tx_space_reg != 7'h00;
            tx_data_out  <= wdata_in;
            tx_space_reg <= tx_space_reg - {6'h00, wr_data && tx_space_reg != 7'h00}
                            + {6'h00, tx_pop_in && tx_space_reg != FIFO_DEPTH};
        end
    end

    // frame length in bit times: start, data, parity, stop
    assign char_bits = 8'h07 + {6'h00, lcr_reg[1:0]} + {7'h00, lcr_reg[3]} + {7'h00, lcr_reg[2]};
    assign trig      = tlr_reg[7:4] == 4'h0 ? 7'h01 : {1'b0, tlr_reg[7:4], 2'b00};

    urs_tick_cnt u_tmo (
        .clock_in (clock_in),
        .rst_in   (rst_int),
        .clear_in (stop_mid_in || rd_data || rx_cnt_reg == 7'h00),
        .tick_in  (bit_tick_in),
        .limit_in (8'(char_bits * TMO_CHARS)),
        .hit_out  (tmo_hit)
    );

    // break counter restarts whenever the line goes high
    urs_tick_cnt u_brk (
        .clock_in (clock_in),
        .rst_in   (rst_int),
        .clear_in (rx_in),
        .tick_in  (bit_tick_in),
        .limit_in (char_bits + 8'h01),
        .hit_out  (brk_hit)
    );

    // one break character per low period
    assign brk_push = brk_hit && !brk_done_reg && !rx_push_in;
    always_ff @(posedge clock_in or posedge rst_int) begin
        if (rst_int) begin
            brk_done_reg <= 1'b0;
        end else if (rx_in) begin
            brk_done_reg <= 1'b0;
        end else if (brk_push) begin
            brk_done_reg <= 1'b1;
        end
    end

    // sticky event flags; a new event wins over a clear in the same cycle
    always_ff @(posedge clock_in or posedge rst_int) begin
        if (rst_int) begin
            ovr_reg       <= 1'b0;
            thr_reg       <= 1'b0;
            stop_src_reg  <= 1'b0;
            spec_src_reg  <= 1'b0;
            rts_chg_reg   <= 1'b0;
            cts_chg_reg   <= 1'b0;
            msr_delta_reg <= 4'h0;
            gpio_chg_reg  <= 8'h00;
        end else begin
            if (push_v && rx_cnt_reg == FIFO_DEPTH) begin
                ovr_reg <= 1'b1;
            end else if (rd_in && addr_in == ADR_LINE_STAT) begin
                ovr_reg <= 1'b0;
            end
            if (tx_pop_in && tx_space_reg == FIFO_DEPTH - 7'h01) begin
                thr_reg <= 1'b1;
            end else if (wr_data || (rd_in && addr_in == ADR_IDENT && ident == ID_TXE)) begin
                thr_reg <= 1'b0;
            end
            if (stop_det_in) begin
                stop_src_reg <= 1'b1;
            end else if (resume_det_in) begin
                stop_src_reg <= 1'b0;
            end
            if (special_det_in) begin
                spec_src_reg <= 1'b1;
            end else if (rd_in && addr_in == ADR_IDENT) begin
                spec_src_reg <= 1'b0;
            end
            if (init_reg && rts_n_out && !rts_d_reg) begin
                rts_chg_reg <= 1'b1;
            end else if (rd_in && addr_in == ADR_IDENT && ident == ID_HS) begin
                rts_chg_reg <= 1'b0;
            end
            if (init_reg && modem_in[0] && !modem_d_reg[0]) begin
                cts_chg_reg <= 1'b1;
            end else if (rd_in && addr_in == ADR_IDENT && ident == ID_HS) begin
                cts_chg_reg <= 1'b0;
            end
            msr_delta_reg <= (init_reg ? (modem_in ^ modem_d_reg) : 4'h0)
                             | (rd_in && addr_in == ADR_MODEM_STAT ? 4'h0 : msr_delta_reg);
            gpio_chg_reg  <= (init_reg ? (gpio_in ^ gpio_d_reg) & ioien_reg : 8'h00)
                             | (rd_in && addr_in == ADR_IO_STATE ? 8'h00 : gpio_chg_reg);
        end
    end

    // line status; head errors hidden when the fifo is empty
    assign line_status_reg = {err_cnt_reg != 7'h00,
                  tx_space_reg == FIFO_DEPTH && tx_shift_empty_in,
                  tx_space_reg == FIFO_DEPTH,
                  rx_cnt_reg != 7'h00 ? head[10:8] : 3'h0,
                  ovr_reg, rx_cnt_reg != 7'h00};

    // gated sources
    assign rls_p  = ier_reg[IEN_RLS] && (line_status_reg[7] || ovr_reg);
    assign tmo_p  = ier_reg[IEN_RXD] && tmo_hit && rx_cnt_reg != 7'h00 && rx_cnt_reg < trig;
    assign rxd_p  = ier_reg[IEN_RXD] && rx_cnt_reg >= trig;
    assign txe_p  = ier_reg[IEN_TXE] && thr_reg;
    assign msr_p  = ier_reg[IEN_MODEM] && msr_delta_reg != 4'h0;
    assign gpio_p = (gpio_chg_reg & ioien_reg) != 8'h00;
    assign flow_p = ier_reg[IEN_FLOW] && (stop_src_reg || spec_src_reg);
    assign hs_p   = (ier_reg[IEN_RTS] && rts_chg_reg) || (ier_reg[IEN_CTS] && cts_chg_reg);

    // priority encoder, level 1 first
    always_comb begin
        if (rls_p) begin
            ident = ID_RLS;
        end else if (tmo_p) begin
            ident = ID_TMO;
        end else if (rxd_p) begin
            ident = ID_RXD;
        end else if (txe_p) begin
            ident = ID_TXE;
        end else if (msr_p) begin
            ident = ID_MODEM;
        end else if (gpio_p) begin
            ident = ID_GPIO;
        end else if (flow_p) begin
            ident = ID_FLOW;
        end else if (hs_p) begin
            ident = ID_HS;
        end else begin
            ident = ID_NONE;
        end
    end

    // open drain: pull low only while an enabled source is pending
    assign irq_out      = 1'b0;
    assign irq_oe_n_out = (ident == ID_NONE);

    // sleep control
    assign sleep_ok = efr_reg[FEAT_ENH] && ier_reg[IEN_SLEEP];
    assign idle = rx_in && rx_cnt_reg == 7'h00 && tx_space_reg == FIFO_DEPTH && tx_shift_empty_in
                  && (ident == ID_NONE || ident == ID_TXE);
    assign wake = !sleep_ok || wr_data || rx_in != rx_d_reg || modem_in != modem_d_reg;
    always_ff @(posedge clock_in or posedge rst_int) begin
        if (rst_int) begin
            slp_reg <= URS_AWAKE;
        end else begin
            case (slp_reg)
                URS_AWAKE:  slp_reg <= (sleep_ok && idle && !wake) ? URS_ASLEEP : URS_AWAKE;
                URS_ASLEEP: slp_reg <= wake ? URS_AWAKE : URS_ASLEEP;
                default:    slp_reg <= URS_AWAKE;
            endcase
        end
    end
    assign sleep_out = (slp_reg == URS_ASLEEP);

    // read mux, captured for the following cycle
    always_comb begin
        case (addr_in)
            ADR_DATA:       rd_mux = rx_cnt_reg != 7'h00 ? head[7:0] : 8'h00;
            ADR_IEN:        rd_mux = ier_reg;
            ADR_IDENT:      rd_mux = {fcr_reg[0], fcr_reg[0], ident};
            ADR_LINE_CTL:   rd_mux = lcr_reg;
            ADR_MODEM_CTL:  rd_mux = mcr_reg;
            ADR_LINE_STAT:  rd_mux = line_status_reg;
            ADR_MODEM_STAT: rd_mux = {modem_in, msr_delta_reg};
            ADR_SCRATCH:    rd_mux = spr_reg;
            ADR_TX_LVL:     rd_mux = {1'b0, tx_space_reg};
            ADR_RX_LVL:     rd_mux = {1'b0, rx_cnt_reg};
            ADR_IO_DIR:     rd_mux = iodir_reg;
            ADR_IO_STATE:   rd_mux = gpio_in;
            ADR_IO_IEN:     rd_mux = ioien_reg;
            ADR_IO_CTL:     rd_mux = ioctl_reg;
            ADR_XFEAT:      rd_mux = efcr_reg;
            ADR_FEAT:       rd_mux = efr_reg;
            ADR_DIV_LO:     rd_mux = dll_reg;
            ADR_DIV_HI:     rd_mux = dlh_reg;
            ADR_FLOW_THR:   rd_mux = tcr_reg;
            ADR_TRIG_THR:   rd_mux = tlr_reg;
            ADR_RESUME1:    rd_mux = res1_reg;
            ADR_RESUME2:    rd_mux = res2_reg;
            ADR_STOP1:      rd_mux = stp1_reg;
            ADR_STOP2:      rd_mux = stp2_reg;
            default:        rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge clock_in or posedge rst_int) begin
        if (rst_int) begin
            rdata_out <= 8'h00;
        end else begin
            rdata_out <= rd_in ? rd_mux : 8'h00;
        end
    end

    // checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_int);

    sequence tx_write_s;
        wr_in && addr_in == ADR_DATA;
    endsequence

    break_hold_a: assert property (lcr_reg[LCTL_BRK] |-> !tx_out)
        else $error("tx not low during break");
    irq_match_a: assert property (!irq_oe_n_out |-> (ier_reg != 8'h00 || ioien_reg != 8'h00))
        else $error("irq pulled low with no enable set");
    head_err_a: assert property (rx_cnt_reg == 7'h00 |-> line_status_reg[4:2] == 3'h0)
        else $error("head error bits set while empty");
    err_sum_a: assert property ($rose(line_status_reg[7]) |-> $past(push_v) && $past(|push_d[10:8]))
        else $error("error summary rose without error push");
    line_prio_a: assert property (rls_p |-> ident == ID_RLS)
        else $error("line status not top priority");
    poll_mode_a: assert property (ier_reg == 8'h00 && ioien_reg == 8'h00 |-> irq_oe_n_out)
        else $error("irq driven in polled mode");
    sleep_gate_a: assert property ($rose(sleep_out) |-> $past(sleep_ok) && $past(idle))
        else $error("sleep entered without permission");
    tx_wake_a: assert property (sleep_out and tx_write_s |=> !sleep_out)
        else $error("tx write did not wake");
    flow_clear_a: assert property (stop_src_reg && resume_det_in && !stop_det_in |=> !stop_src_reg)
        else $error("flow stop not cleared by resume");
endmodule : urs_ctrl

// [rtl/urs_pkg.sv]
package urs_pkg;
    // register offsets on the 5-bit register port
    localparam logic [4:0] ADR_DATA       = 5'h00;
    localparam logic [4:0] ADR_IEN        = 5'h01;
    localparam logic [4:0] ADR_IDENT      = 5'h02;
    localparam logic [4:0] ADR_LINE_CTL   = 5'h03;
    localparam logic [4:0] ADR_MODEM_CTL  = 5'h04;
    localparam logic [4:0] ADR_LINE_STAT  = 5'h05;
    localparam logic [4:0] ADR_MODEM_STAT = 5'h06;
    localparam logic [4:0] ADR_SCRATCH    = 5'h07;
    localparam logic [4:0] ADR_TX_LVL     = 5'h08;
    localparam logic [4:0] ADR_RX_LVL     = 5'h09;
    localparam logic [4:0] ADR_IO_DIR     = 5'h0a;
    localparam logic [4:0] ADR_IO_STATE   = 5'h0b;
    localparam logic [4:0] ADR_IO_IEN     = 5'h0c;
    localparam logic [4:0] ADR_IO_CTL     = 5'h0d;
    localparam logic [4:0] ADR_XFEAT      = 5'h0e;
    localparam logic [4:0] ADR_FEAT       = 5'h0f;
    localparam logic [4:0] ADR_DIV_LO     = 5'h10;
    localparam logic [4:0] ADR_DIV_HI     = 5'h11;
    localparam logic [4:0] ADR_FLOW_THR   = 5'h12;
    localparam logic [4:0] ADR_TRIG_THR   = 5'h13;
    localparam logic [4:0] ADR_RESUME1    = 5'h14;
    localparam logic [4:0] ADR_RESUME2    = 5'h15;
    localparam logic [4:0] ADR_STOP1      = 5'h16;
    localparam logic [4:0] ADR_STOP2      = 5'h17;
    // reset values
    localparam logic [7:0] LINE_CTL_RST   = 8'h1d;
    localparam logic [6:0] TX_SPACE_RST   = 7'h40;
    // identification codes
    localparam logic [5:0] ID_NONE        = 6'h01;
    localparam logic [5:0] ID_RLS         = 6'h06;
    localparam logic [5:0] ID_TMO         = 6'h0c;
    localparam logic [5:0] ID_RXD         = 6'h04;
    localparam logic [5:0] ID_TXE         = 6'h02;
    localparam logic [5:0] ID_MODEM       = 6'h00;
    localparam logic [5:0] ID_GPIO        = 6'h30;
    localparam logic [5:0] ID_FLOW        = 6'h10;
    localparam logic [5:0] ID_HS          = 6'h20;
    // field positions
    localparam int IEN_RXD   = 0;
    localparam int IEN_TXE   = 1;
    localparam int IEN_RLS   = 2;
    localparam int IEN_MODEM = 3;
    localparam int IEN_SLEEP = 4;
    localparam int IEN_FLOW  = 5;
    localparam int IEN_RTS   = 6;
    localparam int IEN_CTS   = 7;
    localparam int FEAT_ENH  = 4;
    localparam int LCTL_BRK  = 6;
    localparam int IOCTL_SWR = 3;
    // timing in character times and fifo size
    localparam logic [7:0] TMO_CHARS = 8'h04;
    localparam logic [6:0] FIFO_DEPTH = 7'h40;
    typedef enum logic [1:0] {URS_AWAKE = 2'b01, URS_ASLEEP = 2'b10} urs_sleep_e;
endpackage : urs_pkg

// [rtl/urs_tick_cnt.sv]
`timescale 1ns/1ps
module urs_tick_cnt (
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_in,
    // count control
    input  wire logic       clear_in,
    input  wire logic       tick_in,
    input  wire logic [7:0] limit_in,
    // result
    output logic            hit_out
);
    logic [7:0] cnt_reg;

    // saturates at the limit so a long idle never wraps back
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_reg <= 8'h00;
        end else if (clear_in) begin
            cnt_reg <= 8'h00;
        end else if (tick_in && !hit_out) begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    assign hit_out = (cnt_reg >= limit_in);
endmodule : urs_tick_cnt

// [dv/urs_host.sv]
`timescale 1ns/1ps
module urs_host (
    // clock
    input  wire logic       clock_in,
    // register port toward the device
    output logic      [4:0] addr_out,
    output logic      [7:0] wdata_out,
    output logic            wr_out,
    output logic            rd_out,
    input  wire logic [7:0] rdata_in
);
    // bus idle from time zero
    initial begin
        addr_out = 5'h00;
        wdata_out = 8'h00;
        wr_out = 1'b0;
        rd_out = 1'b0;
    end

    // one-cycle strobe; divisor is only written while awake by the callers
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] v);
        @(posedge clock_in);
        addr_out <= a;
        wdata_out <= v;
        wr_out <= 1'b1;
        @(posedge clock_in);
        wr_out <= 1'b0;
    endtask : wr_reg

    // data stands only in the cycle after the strobe, so take it at that edge
    task automatic rd_reg(input logic [4:0] a, output logic [7:0] v);
        @(posedge clock_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clock_in);
        rd_out <= 1'b0;
        @(posedge clock_in);
        v = rdata_in;
    endtask : rd_reg
endmodule : urs_host

// [dv/urs_ctrl_tb.sv]
`timescale 1ns/1ps
module urs_ctrl_tb;
    import urs_pkg::*;
    logic        clock_in, rst_in, rx_in, tx_ser_in, bit_tick_in, rx_push_in, stop_mid_in, tx_pop_in;
    logic [7:0]  rx_data_in, wdata, rdata, d, gpio_oe_n;
    logic [2:0]  rx_err_in;
    logic [1:0]  flow_det;
    logic [3:0]  modem_in;
    logic [4:0]  addr;
    logic        wr, rd, tx_out, dtr_n, rts_n, irq, irq_oe_n, sleep;
    logic [15:0] div;
    int          fail_count, cmp_count;
    wire         irq_n = irq_oe_n ? 1'b1 : irq; // external pull-up on the line

    urs_host u_host (.clock_in(clock_in), .addr_out(addr), .wdata_out(wdata), .wr_out(wr),
        .rd_out(rd), .rdata_in(rdata));
    urs_ctrl u_dut (.clock_in(clock_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
        .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .rx_in(rx_in), .tx_ser_in(tx_ser_in),
        .bit_tick_in(bit_tick_in), .tx_out(tx_out), .rx_push_in(rx_push_in), .rx_data_in(rx_data_in),
        .rx_err_in(rx_err_in), .stop_mid_in(stop_mid_in), .tx_pop_in(tx_pop_in),
        .tx_shift_empty_in(1'b1), .tx_load_out(), .tx_data_out(), .resume_det_in(flow_det[0]),
        .stop_det_in(flow_det[1]), .special_det_in(1'b0), .modem_in(modem_in), .dtr_n_out(dtr_n),
        .rts_n_out(rts_n), .gpio_in(8'h00), .gpio_out(), .gpio_oe_n_out(gpio_oe_n), .irq_out(irq),
        .irq_oe_n_out(irq_oe_n), .sleep_out(sleep), .divisor_out(div));

    // 50 ns clock
    initial begin
        clock_in = 1'b0;
        forever #25 clock_in = ~clock_in;
    end

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        u_host.rd_reg(a, d);
        chk(d, e);
    endtask : rdc

    // receiver hands over one character
    task automatic push(input logic [7:0] v, input logic [2:0] e);
        @(posedge clock_in);
        rx_data_in <= v;
        rx_err_in <= e;
        rx_push_in <= 1'b1;
        @(posedge clock_in);
        rx_push_in <= 1'b0;
    endtask : push

    // gapped bit ticks, one cycle high each
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clock_in);
            bit_tick_in <= 1'b1;
            @(posedge clock_in);
            bit_tick_in <= 1'b0;
        end
    endtask : tick

    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #200us;
        fail_count++;
        report_and_stop();
    end

    initial begin
        {rx_in, tx_ser_in, rst_in} = 3'b111;
        {flow_det, bit_tick_in, rx_push_in, stop_mid_in, tx_pop_in} = 6'h00;
        rx_data_in = 8'h00;
        rx_err_in = 3'h0;
        modem_in = 4'hf;
        repeat (20) @(posedge clock_in);
        rst_in <= 1'b0;
        rdc(ADR_IDENT, 8'h01);
        rdc(ADR_LINE_CTL, 8'h1d);
        rdc(ADR_LINE_STAT, 8'h60);
        rdc(ADR_TX_LVL, 8'h40);
        rdc(ADR_RX_LVL, 8'h00);
        rdc(5'h1f, 8'h00);
        rdc(ADR_MODEM_STAT, 8'hf0);
        chk({5'h00, dtr_n, rts_n, irq_n}, 8'h07);
        chk(gpio_oe_n, 8'hff);
        $display("reset values test done");
        u_host.wr_reg(ADR_SCRATCH, 8'h5a);
        u_host.wr_reg(ADR_DIV_LO, 8'h34);
        u_host.wr_reg(ADR_DIV_HI, 8'h12);
        u_host.wr_reg(ADR_IEN, 8'h0f);
        u_host.wr_reg(ADR_LINE_CTL, 8'h03);
        u_host.wr_reg(ADR_TRIG_THR, 8'h10);
        u_host.wr_reg(ADR_IO_CTL, 8'h08);
        repeat (2) @(posedge clock_in);
        rdc(ADR_SCRATCH, 8'h5a);
        chk(div[15:8], 8'h12);
        chk(div[7:0], 8'h34);
        rdc(ADR_IEN, 8'h00);
        rdc(ADR_LINE_CTL, 8'h1d);
        rdc(ADR_TRIG_THR, 8'h00);
        $display("software reset test done");
        u_host.wr_reg(ADR_IEN, 8'h07);
        push(8'h41, 3'b000);
        push(8'h43, 3'b010);
        @(posedge clock_in);
        chk({7'h00, irq_n}, 8'h00);
        rdc(ADR_IDENT, 8'h06);
        rdc(ADR_LINE_STAT, 8'he1);
        rdc(ADR_DATA, 8'h41);
        rdc(ADR_LINE_STAT, 8'he9);
        rdc(ADR_DATA, 8'h43);
        rdc(ADR_LINE_STAT, 8'h60);
        rdc(ADR_IDENT, 8'h01);
        push(8'h44, 3'b000);
        rdc(ADR_IDENT, 8'h04);
        rdc(ADR_DATA, 8'h44);
        u_host.wr_reg(ADR_DATA, 8'h55);
        rdc(ADR_TX_LVL, 8'h3f);
        @(posedge clock_in);
        tx_pop_in <= 1'b1;
        @(posedge clock_in);
        tx_pop_in <= 1'b0;
        rdc(ADR_IDENT, 8'h02);
        rdc(ADR_IDENT, 8'h01);
        u_host.wr_reg(ADR_IEN, 8'h00);
        push(8'h46, 3'b001);
        @(posedge clock_in);
        chk({7'h00, irq_n}, 8'h01);
        rdc(ADR_LINE_STAT, 8'he5);
        rdc(ADR_DATA, 8'h46);
        u_host.wr_reg(ADR_IEN, 8'h20);
        flow_det <= 2'b10;
        @(posedge clock_in);
        flow_det <= 2'b00;
        rdc(ADR_IDENT, 8'h10);
        rdc(ADR_IDENT, 8'h10);
        flow_det <= 2'b01;
        @(posedge clock_in);
        flow_det <= 2'b00;
        rdc(ADR_IDENT, 8'h01);
        $display("interrupt test done");
        u_host.wr_reg(ADR_TRIG_THR, 8'h10);
        u_host.wr_reg(ADR_IEN, 8'h01);
        push(8'h47, 3'b000);
        tick(30);
        @(posedge clock_in);
        stop_mid_in <= 1'b1;
        @(posedge clock_in);
        stop_mid_in <= 1'b0;
        tick(38);
        rdc(ADR_IDENT, 8'h01);
        tick(4);
        rdc(ADR_IDENT, 8'h0c);
        rdc(ADR_DATA, 8'h47);
        rx_in <= 1'b0;
        tick(12);
        rx_in <= 1'b1;
        rdc(ADR_LINE_STAT, 8'hf1);
        rdc(ADR_DATA, 8'h00);
        u_host.wr_reg(ADR_LINE_CTL, 8'h5d);
        @(posedge clock_in);
        chk({7'h00, tx_out}, 8'h00);
        u_host.wr_reg(ADR_LINE_CTL, 8'h1d);
        @(posedge clock_in);
        chk({7'h00, tx_out}, 8'h01);
        $display("timeout and break test done");
        u_host.wr_reg(ADR_IEN, 8'h10);
        repeat (3) @(posedge clock_in);
        chk({7'h00, sleep}, 8'h00);
        u_host.wr_reg(ADR_FEAT, 8'h10);
        repeat (3) @(posedge clock_in);
        chk({7'h00, sleep}, 8'h01);
        modem_in <= 4'h3;
        @(posedge clock_in);
        #1 chk({7'h00, sleep}, 8'h00);
        repeat (3) @(posedge clock_in);
        chk({7'h00, sleep}, 8'h01);
        u_host.wr_reg(ADR_DATA, 8'h66);
        #1 chk({7'h00, sleep}, 8'h00);
        $display("sleep test done");
        report_and_stop();
    end
endmodule : urs_ctrl_tb
